// ---- hw/lpsc_pkg.sv ----
// constants and types shared by the line protection switch controller
package lpsc_pkg;

    // register byte offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_DEBOUNCE = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;
    localparam logic [11:0] OFF_KBYTES = 12'h00c;

    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_LOCKOUT = 2;
    localparam int CTRL_FORCE = 3;
    localparam int CTRL_MANUAL = 4;
    localparam int CTRL_RDI_SUPPRESS = 5;
    localparam logic [5:0] CTRL_RESET = 6'h00;

    // debounce register fields, thresholds in clock cycles
    localparam int DEB_SF_LSB = 0;
    localparam int DEB_SD_LSB = 16;
    localparam logic [15:0] DEB_RESET = 16'h0000;

    // kbyte register fields
    localparam int KB_TX_K1_LSB = 0;
    localparam int KB_TX_K2_LSB = 8;
    localparam int KB_RX_K1_LSB = 16;
    localparam int KB_RX_K2_LSB = 24;

    // status register fields
    localparam int ST_RX_SEL = 0;
    localparam int ST_WORK_TX = 1;
    localparam int ST_PROT_TX = 2;
    localparam int ST_WORK_AIS = 3;
    localparam int ST_PROT_AIS = 4;
    localparam int ST_WORK_SF = 5;
    localparam int ST_PROT_SF = 6;
    localparam int ST_WORK_SD = 7;
    localparam int ST_PROT_SD = 8;

    // switching modes
    typedef enum logic [1:0] {
        MODE_BIDIR = 2'b00,
        MODE_UNI_SIG = 2'b01,
        MODE_UNI_BRIDGE = 2'b10
    } lpsc_mode_t;

    // circuit encoded as its channel number
    typedef enum logic [0:0] {
        CIRC_PROT = 1'b0,
        CIRC_WORK = 1'b1
    } lpsc_circ_t;

    // request codes, higher value ranks higher
    localparam logic [3:0] REQ_LOCKOUT = 4'hf;
    localparam logic [3:0] REQ_FORCE = 4'he;
    localparam logic [3:0] REQ_SF_HIGH = 4'hd;
    localparam logic [3:0] REQ_SF_LOW = 4'hc;
    localparam logic [3:0] REQ_SD_HIGH = 4'hb;
    localparam logic [3:0] REQ_SD_LOW = 4'ha;
    localparam logic [3:0] REQ_MANUAL = 4'h8;
    localparam logic [3:0] REQ_WTR = 4'h6;
    localparam logic [3:0] REQ_EXERCISE = 4'h4;
    localparam logic [3:0] REQ_REVERSE = 4'h2;
    localparam logic [3:0] REQ_NO_REVERT = 4'h1;
    localparam logic [3:0] REQ_NONE = 4'h0;

    // channel numbers
    localparam logic [3:0] CH_PROT = 4'h0;
    localparam logic [3:0] CH_WORK = 4'h1;
    localparam logic [3:0] CH_EXTRA = 4'hf;

    // k2 low nibble: architecture bit and mode field
    localparam logic ARCH_1PLUS1 = 1'b0;
    localparam logic ARCH_1FORN = 1'b1;
    localparam logic [2:0] K2_LAIS = 3'h7;
    localparam logic [2:0] K2_LRDI = 3'h6;
    localparam logic [2:0] K2_BIDIR = 3'h5;
    localparam logic [2:0] K2_UNIDIR = 3'h4;

    // timing
    localparam int CLK_HZ = 40000000;
    localparam int OUTAGE_MS = 100;
    localparam int AIS_MOMENT_MS = 10;
    localparam int AIS_MOMENT_CYC = (CLK_HZ / 1000) * AIS_MOMENT_MS;
    localparam int AIS_CNT_W = 20;

endpackage : lpsc_pkg

// ---- hw/lpsc_cond_if.sv ----
// per-circuit condition carrier between the controller and a monitor
`timescale 1ns/1ps
`default_nettype none
interface lpsc_cond_if;
    logic [15:0] sf_thr;
    logic [15:0] sd_thr;
    logic sf;
    logic sd;
    modport mon (input sf_thr, input sd_thr, output sf, output sd);
    modport ctl (output sf_thr, output sd_thr, input sf, input sd);
endinterface : lpsc_cond_if
`default_nettype wire

// ---- hw/lpsc_cond_mon.sv ----
// signal fail and degrade synchroniser and debounce for one circuit
`timescale 1ns/1ps
`default_nettype none
module lpsc_cond_mon (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sf_pin,
    input wire logic sd_pin,
    lpsc_cond_if.mon cond
);
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] stable;
    logic [1:0] deb;
    logic [15:0] cnt [2];
    logic [15:0] thr [2];

    assign thr[0] = cond.sf_thr;
    assign thr[1] = cond.sd_thr;

    // three-stage synchroniser, first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= 2'h0;
            s2 <= 2'h0;
            s3 <= 2'h0;
        end else begin
            s1 <= {sd_pin, sf_pin};
            s2 <= s1;
            s3 <= s2;
        end
    end

    // a pin change counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stable <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (s2[i] == s3[i]) begin
                    stable[i] <= s3[i];
                end
            end
        end
    end

    // debounce: new level must persist for the threshold count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deb <= 2'h0;
            cnt[0] <= 16'h0000;
            cnt[1] <= 16'h0000;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (stable[i] == deb[i]) begin
                    cnt[i] <= 16'h0000;
                end else if (cnt[i] >= thr[i]) begin
                    deb[i] <= stable[i];
                    cnt[i] <= 16'h0000;
                end else begin
                    cnt[i] <= cnt[i] + 16'h0001;
                end
            end
        end
    end

    assign cond.sf = deb[0];
    assign cond.sd = deb[1];
endmodule // lpsc_cond_mon
`default_nettype wire

// ---- hw/lpsc_ctrl.sv ----
// 1+1 line protection switch controller with kbyte signalling and apb registers
//
// How it works
// - signalling modes transmit on active circuit only
// - receive choice uses local and far-end state
// - signalling modes follow far end when it moves receiver
// - announce receive changes in kbytes
// - transmit always follows receive in signalling modes
// - bidirectional picks higher of local, remote request
// - alarms monitored separately per circuit
// - single failure outage under 100 ms
// - unidirectional kbytes carry local requests only
// - local switch moves tx, alarm on old
// - no local switch if far end blocks
// - follow usable far-end switch in unidirectional signalling
// - alarm pushes far end off unusable circuit
// - alarm persistent in two cases, else momentary
// - bridged mode selects receive by local requests
// - bridged mode transmits on both circuits
// - bridged mode ignores received remote defect
// - bridged mode debounce and defect suppression
// - high request codes and their ranking
// - low request codes, some unused
// - channel 0 protection, 1 working
// - lockout on channel 0, channel 15 idle
// - k2 architecture bit and mode field
`timescale 1ns/1ps
`default_nettype none
module lpsc_ctrl #(
    parameter int AIS_MOMENT_CYC = lpsc_pkg::AIS_MOMENT_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic work_sf_pin,
    input wire logic work_sd_pin,
    input wire logic prot_sf_pin,
    input wire logic prot_sd_pin,
    input wire logic work_rdi_rx,
    input wire logic prot_rdi_rx,
    input wire logic [7:0] rx_k1,
    input wire logic [7:0] rx_k2,
    input wire logic rx_k_valid,
    output logic [7:0] tx_k1,
    output logic [7:0] tx_k2,
    output logic rx_sel,
    output logic work_tx_en,
    output logic prot_tx_en,
    output logic work_ais,
    output logic prot_ais,
    output logic work_rdi_gen,
    output logic prot_rdi_gen
);
    // local request: pick highest ranking condition, returns {code, channel}
    function automatic logic [7:0] local_req(input logic lockout, input logic force_sw,
                                             input logic manual, input logic sf_p,
                                             input logic sf_w, input logic sd_p,
                                             input logic sd_w);
        logic [7:0] r;
        r = {lpsc_pkg::REQ_NONE, lpsc_pkg::CH_PROT};
        if (lockout) begin
            r = {lpsc_pkg::REQ_LOCKOUT, lpsc_pkg::CH_PROT};
        end else if (force_sw) begin
            r = {lpsc_pkg::REQ_FORCE, lpsc_pkg::CH_WORK};
        end else if (sf_p) begin
            r = {lpsc_pkg::REQ_SF_LOW, lpsc_pkg::CH_PROT};
        end else if (sf_w) begin
            r = {lpsc_pkg::REQ_SF_LOW, lpsc_pkg::CH_WORK};
        end else if (sd_p) begin
            r = {lpsc_pkg::REQ_SD_LOW, lpsc_pkg::CH_PROT};
        end else if (sd_w) begin
            r = {lpsc_pkg::REQ_SD_LOW, lpsc_pkg::CH_WORK};
        end else if (manual) begin
            r = {lpsc_pkg::REQ_MANUAL, lpsc_pkg::CH_WORK};
        end
        return r;
    endfunction

    // a request on a channel moves traffic to the other circuit
    function automatic lpsc_pkg::lpsc_circ_t req_target(input logic [3:0] ch);
        return (ch == lpsc_pkg::CH_WORK) ? lpsc_pkg::CIRC_PROT : lpsc_pkg::CIRC_WORK;
    endfunction

    // only the used codes are meaningful from the far end
    function automatic logic code_used(input logic [3:0] c);
        return !(c == 4'h9 || c == 4'h7 || c == 4'h5 || c == 4'h3);
    endfunction

    // registers
    localparam int AIS_CNT_W = lpsc_pkg::AIS_CNT_W;
    logic [5:0] ctrl;
    logic [15:0] sf_deb;
    logic [15:0] sd_deb;
    logic [7:0] rk1;
    logic [7:0] rk2;
    lpsc_pkg::lpsc_circ_t active;
    lpsc_pkg::lpsc_circ_t far_rx;
    logic far_chg;
    logic [lpsc_pkg::AIS_CNT_W-1:0] ais_cnt [2];
    logic [1:0] ais_fire;
    logic [1:0] ais_hold;

    lpsc_pkg::lpsc_mode_t mode;
    logic bridged;
    logic sf_p;
    logic sf_w;
    logic sd_p;
    logic sd_w;
    logic [7:0] lreq;
    logic [3:0] rem_code;
    logic [3:0] rem_ch;
    logic rem_valid;
    lpsc_pkg::lpsc_circ_t next_active;

    lpsc_cond_if work_c ();
    lpsc_cond_if prot_c ();

    // debounce thresholds only in bridged mode
    assign work_c.sf_thr = bridged ? sf_deb : 16'h0000;
    assign work_c.sd_thr = bridged ? sd_deb : 16'h0000;
    assign prot_c.sf_thr = bridged ? sf_deb : 16'h0000;
    assign prot_c.sd_thr = bridged ? sd_deb : 16'h0000;

    lpsc_cond_mon u_work_mon (
        .pclk(pclk),
        .presetn(presetn),
        .sf_pin(work_sf_pin),
        .sd_pin(work_sd_pin),
        .cond(work_c.mon)
    );

    lpsc_cond_mon u_prot_mon (
        .pclk(pclk),
        .presetn(presetn),
        .sf_pin(prot_sf_pin),
        .sd_pin(prot_sd_pin),
        .cond(prot_c.mon)
    );

    // mode decode, spare encoding behaves as bidirectional
    always_comb begin
        case (ctrl[lpsc_pkg::CTRL_MODE_LSB +: 2])
            2'b01: mode = lpsc_pkg::MODE_UNI_SIG;
            2'b10: mode = lpsc_pkg::MODE_UNI_BRIDGE;
            default: mode = lpsc_pkg::MODE_BIDIR;
        endcase
    end
    assign bridged = (mode == lpsc_pkg::MODE_UNI_BRIDGE);

    // local conditions; received remote defect counts as degrade
    assign sf_p = prot_c.sf;
    assign sf_w = work_c.sf;
    // bridged mode leaves a defect-reporting circuit in service
    assign sd_p = prot_c.sd | (prot_rdi_rx & !bridged);
    assign sd_w = work_c.sd | (work_rdi_rx & !bridged);

    assign lreq = local_req(ctrl[lpsc_pkg::CTRL_LOCKOUT], ctrl[lpsc_pkg::CTRL_FORCE],
                            ctrl[lpsc_pkg::CTRL_MANUAL], sf_p, sf_w, sd_p, sd_w);

    // far-end request, invalid combinations treated as none
    assign rem_code = rk1[7:4];
    assign rem_ch = rk1[3:0];
    // lockout only on channel 0, channel 15 only idle
    assign rem_valid = code_used(rem_code) && (rem_code != lpsc_pkg::REQ_NONE)
                       && (rem_ch == lpsc_pkg::CH_PROT || rem_ch == lpsc_pkg::CH_WORK)
                       && !(rem_code == lpsc_pkg::REQ_LOCKOUT && rem_ch != lpsc_pkg::CH_PROT);

    // capture received kbytes and spot a move of the far receiver
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rk1 <= 8'h00;
            rk2 <= 8'h00;
            far_rx <= lpsc_pkg::CIRC_WORK;
            far_chg <= 1'b0;
        end else begin
            far_chg <= 1'b0;
            if (rx_k_valid) begin
                rk1 <= rx_k1;
                rk2 <= rx_k2;
                // only channels 0 and 1 are followed
                if (rx_k2[7:5] == 3'h0 && rx_k2[4] != far_rx) begin
                    far_rx <= lpsc_pkg::lpsc_circ_t'(rx_k2[4]);
                    far_chg <= 1'b1;
                end
            end
        end
    end

    // switch decision, combinational in the same cycle the condition settles
    always_comb begin
        lpsc_pkg::lpsc_circ_t lt;
        logic lwant;
        logic usable;
        lt = req_target(lreq[3:0]);
        lwant = (lreq[7:4] != lpsc_pkg::REQ_NONE);
        usable = 1'b0;
        next_active = active;
        ais_fire = 2'b00;
        case (mode)
            lpsc_pkg::MODE_UNI_SIG: begin
                if (lwant && lt != active) begin
                    // remote lockout keeps us off protection
                    if (!(lt == lpsc_pkg::CIRC_PROT && rem_valid
                          && rem_code == lpsc_pkg::REQ_LOCKOUT)) begin
                        // move tx, alarm on old circuit
                        next_active = lt;
                        ais_fire[active] = 1'b1;
                    end
                end else if (far_chg && far_rx != active) begin
                    usable = !(lwant && lt != far_rx)
                             && !(far_rx == lpsc_pkg::CIRC_PROT
                                  && (sf_p || ctrl[lpsc_pkg::CTRL_LOCKOUT]))
                             && !(far_rx == lpsc_pkg::CIRC_WORK && sf_w);
                    if (usable) begin
                        next_active = far_rx;
                    end else begin
                        ais_fire[far_rx] = 1'b1;
                    end
                end
            end
            lpsc_pkg::MODE_UNI_BRIDGE: begin
                if (lwant) begin
                    next_active = lt;
                end
            end
            default: begin
                // higher of local and remote request wins
                if (rem_valid && rem_code > lreq[7:4]) begin
                    next_active = req_target(rem_ch);
                end else if (lwant) begin
                    next_active = lt;
                end else if (far_chg) begin
                    next_active = far_rx;
                end
            end
        endcase
    end

    // switch completes one cycle after debounce, far below 100 ms
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active <= lpsc_pkg::CIRC_WORK;
        end else begin
            active <= next_active;
        end
    end

    // persistent alarm cases, only in unidirectional signalling
    always_comb begin
        ais_hold = 2'b00;
        if (mode == lpsc_pkg::MODE_UNI_SIG) begin
            ais_hold[lpsc_pkg::CIRC_PROT] = (active == lpsc_pkg::CIRC_WORK)
                && (sf_p || ctrl[lpsc_pkg::CTRL_LOCKOUT]);
            ais_hold[lpsc_pkg::CIRC_WORK] = (active == lpsc_pkg::CIRC_PROT)
                && (lreq[7:4] != lpsc_pkg::REQ_NONE)
                && (req_target(lreq[3:0]) == lpsc_pkg::CIRC_PROT);
        end
    end

    // momentary alarm timers, one per circuit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ais_cnt[0] <= '0;
            ais_cnt[1] <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (ais_fire[i]) begin
                    ais_cnt[i] <= AIS_CNT_W'(AIS_MOMENT_CYC);
                end else if (ais_cnt[i] != '0) begin
                    ais_cnt[i] <= ais_cnt[i] - AIS_CNT_W'(1);
                end
            end
        end
    end

    // datapath steering and alarm outputs, all registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sel <= 1'b1;
            work_tx_en <= 1'b1;
            prot_tx_en <= 1'b0;
            work_ais <= 1'b0;
            prot_ais <= 1'b0;
            work_rdi_gen <= 1'b0;
            prot_rdi_gen <= 1'b0;
        end else begin
            rx_sel <= next_active;
            // otherwise only the active one, same as receive
            work_tx_en <= bridged || (next_active == lpsc_pkg::CIRC_WORK);
            prot_tx_en <= bridged || (next_active == lpsc_pkg::CIRC_PROT);
            work_ais <= ais_hold[1] || (ais_cnt[1] != '0) || ais_fire[1];
            prot_ais <= ais_hold[0] || (ais_cnt[0] != '0) || ais_fire[0];
            // defect indication can be suppressed in bridged mode
            work_rdi_gen <= sf_w && !(bridged && ctrl[lpsc_pkg::CTRL_RDI_SUPPRESS]);
            prot_rdi_gen <= sf_p && !(bridged && ctrl[lpsc_pkg::CTRL_RDI_SUPPRESS]);
        end
    end

    // transmitted kbytes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_k1 <= {lpsc_pkg::REQ_NONE, lpsc_pkg::CH_PROT};
            tx_k2 <= {lpsc_pkg::CH_WORK, lpsc_pkg::ARCH_1PLUS1, lpsc_pkg::K2_BIDIR};
        end else begin
            // request nibble built from local state only
            tx_k1 <= lreq;
            // channel nibble tracks the selected receiver
            // architecture bit and switching mode field
            tx_k2 <= {3'h0, next_active, lpsc_pkg::ARCH_1PLUS1,
                      (mode == lpsc_pkg::MODE_BIDIR) ? lpsc_pkg::K2_BIDIR
                                                     : lpsc_pkg::K2_UNIDIR};
        end
    end

    // apb slave: zero wait states, error on unmapped address
    logic wr_en;
    logic hit;
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign hit = (paddr == lpsc_pkg::OFF_CTRL) || (paddr == lpsc_pkg::OFF_DEBOUNCE)
                 || (paddr == lpsc_pkg::OFF_STATUS) || (paddr == lpsc_pkg::OFF_KBYTES);
    assign pslverr = psel && penable && !hit;

    // writable registers, byte strobes honoured
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= lpsc_pkg::CTRL_RESET;
            sf_deb <= lpsc_pkg::DEB_RESET;
            sd_deb <= lpsc_pkg::DEB_RESET;
        end else if (wr_en) begin
            if (paddr == lpsc_pkg::OFF_CTRL) begin
                if (pstrb[0]) begin
                    ctrl <= pwdata[5:0];
                end
            end else if (paddr == lpsc_pkg::OFF_DEBOUNCE) begin
                if (pstrb[0]) begin
                    sf_deb[7:0] <= pwdata[7:0];
                end
                if (pstrb[1]) begin
                    sf_deb[15:8] <= pwdata[15:8];
                end
                if (pstrb[2]) begin
                    sd_deb[7:0] <= pwdata[23:16];
                end
                if (pstrb[3]) begin
                    sd_deb[15:8] <= pwdata[31:24];
                end
            end
        end
    end

    // read mux, registered so read data comes from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == lpsc_pkg::OFF_CTRL) begin
                prdata <= {26'h0, ctrl};
            end else if (paddr == lpsc_pkg::OFF_DEBOUNCE) begin
                prdata <= {sd_deb, sf_deb};
            end else if (paddr == lpsc_pkg::OFF_STATUS) begin
                prdata <= {23'h0, sd_p, sd_w, sf_p, sf_w, prot_ais, work_ais,
                           prot_tx_en, work_tx_en, rx_sel};
            end else if (paddr == lpsc_pkg::OFF_KBYTES) begin
                prdata <= {rk2, rk1, tx_k2, tx_k1};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end
endmodule // lpsc_ctrl
`default_nettype wire

// ---- sim/lpsc_sva.sv ----
// assertion checker for the line protection switch controller
`timescale 1ns/1ps
`default_nettype none
module lpsc_sva #(
    parameter int AIS_MOMENT_CYC = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic rx_k_valid,
    input wire logic rx_sel,
    input wire logic work_tx_en,
    input wire logic prot_tx_en,
    input wire logic work_ais,
    input wire logic [7:0] tx_k1,
    input wire logic [7:0] tx_k2
);
    logic [1:0] mode_q;
    logic [1:0] mode_d;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // shadow of the mode field, delayed so outputs have settled after a change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 2'h0;
            mode_d <= 2'h0;
        end else begin
            if (psel && penable && pwrite && pstrb[0] && paddr == lpsc_pkg::OFF_CTRL) begin
                mode_q <= (pwdata[1:0] == 2'h3) ? 2'h0 : pwdata[1:0];
            end
            mode_d <= mode_q;
        end
    end
    // a switch from working not caused by a received kbyte pair
    sequence local_drop;
        mode_q == 2'h1 && mode_d == 2'h1 && $fell(rx_sel) && !$past(rx_k_valid, 2);
    endsequence
    single_tx_a: assert property (mode_q != 2'h2 && mode_d != 2'h2 |-> work_tx_en != prot_tx_en)
        else $error("transmit on both or neither circuit");
    tx_follow_a: assert property (mode_q != 2'h2 && mode_d != 2'h2 |-> work_tx_en == rx_sel)
        else $error("transmit circuit differs from receive");
    bridge_both_a: assert property (mode_q == 2'h2 && mode_d == 2'h2 |-> work_tx_en && prot_tx_en)
        else $error("bridged mode not sending on both");
    chan_announce_a: assert property (tx_k2[7:4] == {3'h0, rx_sel})
        else $error("sent channel differs from receive circuit");
    k2_mode_a: assert property (mode_q == mode_d |-> tx_k2[3:0] == ((mode_d == 2'h0) ? 4'h5 : 4'h4))
        else $error("sent mode field wrong");
    lockout_ch_a: assert property (tx_k1[7:4] == lpsc_pkg::REQ_LOCKOUT |-> tx_k1[3:0] == 4'h0)
        else $error("lockout sent on nonzero channel");
    code_used_a: assert property (!(tx_k1[7:4] inside {4'h9, 4'h7, 4'h5, 4'h3}) && tx_k1[3:0] <= 4'h1)
        else $error("unused code or channel sent");
    old_ais_a: assert property (local_drop |-> work_ais)
        else $error("no alarm on old transmit circuit");
endmodule // lpsc_sva
bind lpsc_ctrl lpsc_sva #(.AIS_MOMENT_CYC(AIS_MOMENT_CYC)) chk_u (.*);
`default_nettype wire

// ---- sim/lpsc_far_end.sv ----
// far-end line terminal model sending kbytes and remote defects
`timescale 1ns/1ps
`default_nettype none
module lpsc_far_end (
    input wire logic pclk,
    output logic [7:0] rx_k1,
    output logic [7:0] rx_k2,
    output logic rx_k_valid,
    output logic work_rdi_rx,
    output logic prot_rdi_rx
);
    // idle line: no request, far end listening on working, bidirectional
    initial begin
        rx_k1 = 8'h00;
        rx_k2 = 8'h15;
        rx_k_valid = 1'b0;
        work_rdi_rx = 1'b0;
        prot_rdi_rx = 1'b0;
    end
    // request, channel, architecture and mode fields
    task automatic report(input logic [3:0] req, input logic [3:0] ch, input logic [3:0] rcv,
                          input logic uni);
        @(posedge pclk);
        rx_k1 <= {req, (req == lpsc_pkg::REQ_LOCKOUT) ? lpsc_pkg::CH_PROT : ch};
        rx_k2 <= {rcv, lpsc_pkg::ARCH_1PLUS1, uni ? lpsc_pkg::K2_UNIDIR : lpsc_pkg::K2_BIDIR};
        rx_k_valid <= 1'b1;
        @(posedge pclk);
        rx_k_valid <= 1'b0;
    endtask
    task automatic defect(input logic w, input logic p);
        @(posedge pclk);
        work_rdi_rx <= w;
        prot_rdi_rx <= p;
    endtask
endmodule // lpsc_far_end
`default_nettype wire

// ---- sim/lpsc_ctrl_tb_top.sv ----
// self-checking bench for the line protection switch controller
`timescale 1ns/1ps
`default_nettype none
`define chk(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; $display("unexpected %s exp %h got %h", n, e, g); end end
module lpsc_ctrl_tb_top;
    localparam int AIS_CYC = 20;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_k_valid, rx_sel;
    logic work_sf_pin, work_sd_pin, prot_sf_pin, prot_sd_pin, work_rdi_rx, prot_rdi_rx;
    logic work_tx_en, prot_tx_en, work_ais, prot_ais, work_rdi_gen, prot_rdi_gen, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [3:0] pstrb;
    logic [7:0] rx_k1, rx_k2, tx_k1, tx_k2;
    int miscompares = 0;
    int comparisons = 0;
    lpsc_ctrl #(.AIS_MOMENT_CYC(AIS_CYC)) dut_u (.*);
    lpsc_far_end far_u (.*);
    // one apb transfer; setup starts an edge after any previous release
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        miscompares += (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_sel(input logic v);
        int n;
        n = 0;
        while (rx_sel !== v && n < 40) begin
            @(posedge pclk);
            #1;
            n++;
        end
        miscompares += (rx_sel !== v);
    endtask
    task automatic t_reset();
        apb(1'b0, lpsc_pkg::OFF_STATUS, 32'h0);
        `chk("status", 9'h003, rdata[8:0])
        apb(1'b0, lpsc_pkg::OFF_KBYTES, 32'h0);
        `chk("kbytes", 16'h1500, rdata[15:0])
        apb(1'b0, 12'h010, 32'h0);
        `chk("unmapped err", 1'b1, rerr)
    endtask
    task automatic t_uni_local();
        apb(1'b1, lpsc_pkg::OFF_CTRL, 32'h1);
        @(posedge pclk);
        work_sf_pin <= 1'b1;
        wait_sel(1'b0);
        `chk("tx_en", 2'b01, {work_tx_en, prot_tx_en})
        `chk("work_ais", 1'b1, work_ais)
        `chk("tx_k2", 8'h04, tx_k2)
        far_u.report(lpsc_pkg::REQ_NONE, lpsc_pkg::CH_PROT, lpsc_pkg::CH_PROT, 1'b1);
        repeat (AIS_CYC + 10) @(posedge pclk);
        #1;
        `chk("ais held", 1'b1, work_ais)
        `chk("tx_k1", 8'hc1, tx_k1)
    endtask
    task automatic t_far_move();
        @(posedge pclk);
        work_sf_pin <= 1'b0;
        repeat (12) @(posedge pclk);
        far_u.report(lpsc_pkg::REQ_NONE, lpsc_pkg::CH_WORK, lpsc_pkg::CH_WORK, 1'b1);
        #1;
        `chk("early move", 1'b0, rx_sel)
        @(posedge pclk);
        #1;
        `chk("far move", 1'b1, rx_sel)
        `chk("tx follows", 2'b10, {work_tx_en, prot_tx_en})
    endtask
    task automatic t_bidir();
        apb(1'b1, lpsc_pkg::OFF_CTRL, 32'h0);
        far_u.report(lpsc_pkg::REQ_FORCE, lpsc_pkg::CH_WORK, lpsc_pkg::CH_WORK, 1'b0);
        wait_sel(1'b0);
        `chk("remote wins", 1'b0, rx_sel)
        apb(1'b1, lpsc_pkg::OFF_CTRL, 32'h4);
        wait_sel(1'b1);
        `chk("local wins", 1'b1, rx_sel)
        `chk("lockout k1", 8'hf0, tx_k1)
    endtask
    task automatic t_bridge();
        apb(1'b1, lpsc_pkg::OFF_CTRL, 32'h2);
        far_u.defect(1'b1, 1'b0);
        repeat (10) @(posedge pclk);
        #1;
        `chk("bridge tx", 2'b11, {work_tx_en, prot_tx_en})
        `chk("rdi kept", 1'b1, rx_sel)
        @(posedge pclk);
        work_sf_pin <= 1'b1;
        wait_sel(1'b0);
        `chk("local sel", 1'b0, rx_sel)
        `chk("rdi gen", 2'b10, {work_rdi_gen, prot_rdi_gen})
        apb(1'b1, lpsc_pkg::OFF_CTRL, 32'h22);
        repeat (3) @(posedge pclk);
        #1;
        `chk("rdi off", 1'b0, work_rdi_gen)
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // reset held 12 cycles with every input parked
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {work_sf_pin, work_sd_pin, prot_sf_pin, prot_sd_pin} = 4'h0;
        pstrb = 4'hf;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_uni_local();
        t_far_move();
        t_bidir();
        t_bridge();
        report_and_stop();
    end
    // hang guard, far beyond the run's length
    initial begin
        #(25 * 20000);
        miscompares++;
        report_and_stop();
    end
endmodule // lpsc_ctrl_tb_top
`default_nettype wire
